// ===== common/tac_pkg.sv
// tac_pkg: shared constants for the touch converter link and its master
// Contract
// - next control byte overlaps result, 16 clocks
// - master finishes each conversion within 1.6ms
// - converter stays powered while clock pauses
// - fastest scheme: continuous 15 clocks per conversion
// - result is unsigned straight binary
// - 8-bit mode ends four clocks sooner
// - 8-bit mode allows 50% faster clock
// - keep bit one full power, zero auto-down
// - single-ended: drivers on only while acquiring
// - differential: drivers on through acquire and convert
// - chip select high aborts conversion, powers down
// - chip select high leaves reference state alone
// - master clears reference bit before raising select; tac_host raises select with the last byte sent unchanged
// - powered after start until keep bit cleared
// - first high data bit is start bit
// - byte fields: channel, resolution, reference, power
// - power pair decodes to reference and converter
// - new byte every 15th or 11th clock
package tac_pkg;
	localparam int CLK_NS = 25;
	localparam int SCLK_HALF_NS = 200;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int CSS_NS = 100;
	localparam int CSS_CYC = (CSS_NS + CLK_NS - 1) / CLK_NS;
	localparam int CSH_NS = 10;
	localparam int CSH_CYC = (CSH_NS + CLK_NS - 1) / CLK_NS;
	localparam int CB_W = 8;
	localparam int CB_CH_LSB = 4;
	localparam int CB_MODE = 3;
	localparam int CB_SER = 2;
	localparam int CB_PD1 = 1;
	localparam int CB_PD0 = 0;
	localparam int CH_N = 8;
	localparam int RES_BITS = 12;
	localparam int RES_SHORTEN = 4;
	localparam int FRAME_STD = 16;
	localparam int FRAME_FAST = 15;
	localparam int ACQ_FROM_BIT = 3;
	localparam logic [1:0] PD_RESET = 2'h1;
	localparam logic [7:0] TOUCH_CH_MASK = 8'h3A;
	localparam int AXI_AW = 6;
	localparam int AXI_NREG = 4;
	localparam logic [5:0] A_CMD = 6'h00;
	localparam logic [5:0] A_STAT = 6'h04;
	localparam logic [5:0] A_RES = 6'h08;
	localparam logic [5:0] A_CFG = 6'h0C;
	localparam int CF_FAST = 0;
	localparam int CF_HOLD = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== common/tac_link_if.sv
// tac_link_if: serial link between the converter and its master
interface tac_link_if;
	logic serial_clock_in;
	logic cs_n;
	logic sdi;
	logic sdo;
	logic sdo_oe;
	logic busy;
	logic busy_oe;
	modport dev (input serial_clock_in, input cs_n, input sdi,
		output sdo, output sdo_oe, output busy, output busy_oe);
	modport host (output serial_clock_in, output cs_n, output sdi,
		input sdo, input sdo_oe, input busy, input busy_oe);
endinterface

// ===== verilog/tac_axil.sv
// tac_axil: axi4-lite slave front end for the master's registers
module tac_axil #(
	parameter int AW = tac_pkg::AXI_AW,
	parameter int NREG = tac_pkg::AXI_NREG
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic [AW-1:0] s_awaddr, // write address
	input wire logic s_awvalid, // write address valid
	output logic s_awready, // write address ready
	input wire logic [31:0] s_wdata, // write data
	input wire logic [3:0] s_wstrb, // write strobes
	input wire logic s_wvalid, // write data valid
	output logic s_wready, // write data ready
	output logic [1:0] s_bresp, // write response
	output logic s_bvalid, // write response valid
	input wire logic s_bready, // write response ready
	input wire logic [AW-1:0] s_araddr, // read address
	input wire logic s_arvalid, // read address valid
	output logic s_arready, // read address ready
	output logic [31:0] s_rdata, // read data
	output logic [1:0] s_rresp, // read response
	output logic s_rvalid, // read valid
	input wire logic s_rready, // read ready
	output logic wr_stb, // register write pulse
	output logic [AW-1:0] wr_addr, // register write address
	output logic [31:0] wr_data, // register write data
	output logic [3:0] wr_strb, // register write strobes
	output logic rd_stb, // register read pulse
	output logic [AW-1:0] rd_addr, // register read address
	input wire logic [31:0] rd_data // register read data
);
	typedef struct packed {
		logic aw_full;
		logic [AW-1:0] awaddr;
		logic w_full;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tac_axil_s;

	tac_axil_s s;
	tac_axil_s n;
	logic wr_go;

	function automatic logic tac_addr_ok(input logic [AW-1:0] a);
		return (a[AW-1:2] < NREG);
	endfunction

	assign wr_go = s.aw_full && s.w_full && !s.bvalid;
	assign wr_stb = wr_go && tac_addr_ok(s.awaddr);
	assign wr_addr = s.awaddr;
	assign wr_data = s.wdata;
	assign wr_strb = s.wstrb;
	assign rd_addr = s_araddr;
	assign rd_stb = s_arvalid && s.arready && tac_addr_ok(s_araddr);

	always_comb begin
		n = s;
		if (s_awvalid && s.awready) begin
			n.aw_full = 1'b1;
			n.awaddr = s_awaddr;
		end
		if (s_wvalid && s.wready) begin
			n.w_full = 1'b1;
			n.wdata = s_wdata;
			n.wstrb = s_wstrb;
		end
		if (s.bvalid && s_bready) begin
			n.bvalid = 1'b0;
		end
		if (wr_go) begin
			n.aw_full = 1'b0;
			n.w_full = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = tac_addr_ok(s.awaddr) ? tac_pkg::RESP_OKAY : tac_pkg::RESP_SLVERR;
		end
		n.awready = !n.aw_full;
		n.wready = !n.w_full;
		if (s.rvalid && s_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_arvalid && s.arready) begin
			n.rvalid = 1'b1;
			n.rdata = tac_addr_ok(s_araddr) ? rd_data : 32'h0;
			n.rresp = tac_addr_ok(s_araddr) ? tac_pkg::RESP_OKAY : tac_pkg::RESP_SLVERR;
		end
		n.arready = !n.rvalid;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign s_awready = s.awready;
	assign s_wready = s.wready;
	assign s_bvalid = s.bvalid;
	assign s_bresp = s.bresp;
	assign s_arready = s.arready;
	assign s_rvalid = s.rvalid;
	assign s_rdata = s.rdata;
	assign s_rresp = s.rresp;
endmodule // tac_axil

// ===== verilog/tac_host.sv
// tac_host: serial master that issues control bytes and collects results
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
module tac_host #(
	parameter int HALF_CYC = tac_pkg::SCLK_HALF_CYC
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // asynchronous reset, active low
	tac_link_if.host link, // serial link to the converter
	input wire logic [tac_pkg::AXI_AW-1:0] s_awaddr, // write address
	input wire logic s_awvalid, // write address valid
	output logic s_awready, // write address ready
	input wire logic [31:0] s_wdata, // write data
	input wire logic [3:0] s_wstrb, // write strobes
	input wire logic s_wvalid, // write data valid
	output logic s_wready, // write data ready
	output logic [1:0] s_bresp, // write response
	output logic s_bvalid, // write response valid
	input wire logic s_bready, // write response ready
	input wire logic [tac_pkg::AXI_AW-1:0] s_araddr, // read address
	input wire logic s_arvalid, // read address valid
	output logic s_arready, // read address ready
	output logic [31:0] s_rdata, // read data
	output logic [1:0] s_rresp, // read response
	output logic s_rvalid, // read valid
	input wire logic s_rready // read ready
);
	typedef enum logic [1:0] {H_IDLE, H_SETUP, H_RUN, H_GAP} tac_hst_e;
	typedef struct packed {
		tac_hst_e st;
		logic [7:0] div;
		logic sclk;
		logic cs_n;
		logic sdi;
		logic tx_on;
		logic [6:0] tx_sh;
		logic [2:0] tx_n;
		logic [4:0] pos;
		logic last_eight;
		logic wait_busy;
		logic [3:0] rx_n;
		logic [11:0] rx_sh;
		logic rx_eight;
		logic [7:0] cmd;
		logic cmd_pend;
		logic fast;
		logic hold;
		logic [11:0] result;
		logic res_valid;
	} tac_host_s;

	localparam tac_host_s HOST_RST = '{st: H_IDLE, cs_n: 1'b1, pos: 5'h1F, default: '0};

	tac_host_s s;
	tac_host_s n;
	logic go;
	logic [4:0] frame;
	logic wr_stb;
	logic rd_stb;
	logic [tac_pkg::AXI_AW-1:0] wr_addr;
	logic [tac_pkg::AXI_AW-1:0] rd_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [31:0] rd_data;

	tac_axil tac_axil_i (
		.clk(clk), .rst_n(rst_n),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb),
		.rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data)
	);

	assign rd_data = (rd_addr == tac_pkg::A_CMD) ? {24'h0, s.cmd} :
		(rd_addr == tac_pkg::A_STAT) ? {29'h0, s.res_valid, s.cmd_pend, s.st != H_IDLE} :
		(rd_addr == tac_pkg::A_RES) ? {20'h0, s.result} :
		(rd_addr == tac_pkg::A_CFG) ? {30'h0, s.hold, s.fast} : 32'h0;

	// start spacing: 16 or 15 clocks, four fewer in 8-bit mode
	assign frame = 5'((s.fast ? tac_pkg::FRAME_FAST : tac_pkg::FRAME_STD)
		- (s.last_eight ? tac_pkg::RES_SHORTEN : 0));

	always_comb begin
		n = s;
		go = 1'b0;
		if (wr_stb && wr_strb[0]) begin
			if (wr_addr == tac_pkg::A_CMD && !s.cmd_pend) begin
				n.cmd = wr_data[7:0];
				n.cmd_pend = 1'b1;
			end
			if (wr_addr == tac_pkg::A_CFG) begin
				n.fast = wr_data[tac_pkg::CF_FAST];
				n.hold = wr_data[tac_pkg::CF_HOLD];
			end
		end
		if (rd_stb && rd_addr == tac_pkg::A_RES) begin
			n.res_valid = 1'b0;
		end
		unique case (s.st)
			H_IDLE: begin
				if (s.cmd_pend && s.cs_n) begin
					n.st = H_SETUP;
					n.cs_n = 1'b0;
					n.div = 8'(tac_pkg::CSS_CYC - 1);
				end else if (s.cmd_pend) begin
					go = 1'b1;
				end
			end
			H_SETUP: begin
				if (s.div == 8'h0) begin
					go = 1'b1;
				end else begin
					n.div = s.div - 8'h1;
				end
			end
			H_RUN: begin
				if (s.div != 8'h0) begin
					n.div = s.div - 8'h1;
				end else if (!s.sclk) begin
					n.div = 8'(HALF_CYC - 1);
					n.sclk = 1'b1;
					if (s.pos != 5'h1F) begin
						n.pos = s.pos + 5'h1;
					end
					if (s.rx_n != 4'h0) begin
						n.rx_sh = {s.rx_sh[10:0], link.sdo};
						n.rx_n = s.rx_n - 4'h1;
						if (s.rx_n == 4'h1) begin
							n.result = s.rx_eight ? {4'h0, n.rx_sh[7:0]} : n.rx_sh;
							n.res_valid = 1'b1;
						end
					end
					if (s.wait_busy && link.busy) begin
						n.wait_busy = 1'b0;
						n.rx_eight = s.last_eight;
						n.rx_n = s.last_eight ? 4'h8 : 4'hC;
					end
				end else begin
					n.div = 8'(HALF_CYC - 1);
					n.sclk = 1'b0;
					n.sdi = 1'b0;
					if (s.tx_on && s.tx_n != 3'h0) begin
						n.sdi = s.tx_sh[6];
						n.tx_sh = {s.tx_sh[5:0], 1'b0};
						n.tx_n = s.tx_n - 3'h1;
					end else if (s.tx_on) begin
						n.tx_on = 1'b0;
						n.wait_busy = 1'b1;
					end else if (s.cmd_pend && s.pos >= frame) begin
						go = 1'b1;
					end else if (!s.cmd_pend && !s.wait_busy && s.rx_n == 4'h0) begin
						// clock keeps running until the result is in
						n.st = H_GAP;
						n.cs_n = !s.hold;
						n.div = 8'(tac_pkg::CSH_CYC - 1);
					end
				end
			end
			H_GAP: begin
				if (s.div == 8'h0) begin
					n.st = H_IDLE;
				end else begin
					n.div = s.div - 8'h1;
				end
			end
		endcase
		if (go) begin
			n.st = H_RUN;
			n.div = 8'(HALF_CYC - 1);
			n.sdi = s.cmd[7];
			n.tx_sh = s.cmd[6:0];
			n.tx_n = 3'h7;
			n.tx_on = 1'b1;
			n.pos = 5'h0;
			n.last_eight = s.cmd[tac_pkg::CB_MODE];
			n.cmd_pend = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= HOST_RST;
		end else begin
			s <= n;
		end
	end

	assign link.serial_clock_in = s.sclk;
	assign link.cs_n = s.cs_n;
	assign link.sdi = s.sdi;
endmodule // tac_host

// ===== verilog/tac_dev.sv
// tac_dev: converter end of the link, conversion sequencing and power state
module tac_dev (
	input wire logic clk, // system clock
	input wire logic rst_n, // asynchronous reset, active low
	tac_link_if.dev link, // serial link to the master
	input wire logic [tac_pkg::CH_N-1:0][tac_pkg::RES_BITS-1:0] analog_code, // code per channel
	input wire logic panel_touched, // panel contact present
	output logic [2:0] channel_select_field, // channel of latest control byte
	output logic touch_drive_on, // panel drivers switched on
	output logic adc_powered, // converter at full power
	output logic ref_powered, // internal reference on
	output logic acquiring, // input being sampled
	output logic touch_irq_n // pen detect, active low
);
	typedef struct packed {
		logic sclk_q;
		logic rx_on;
		logic [2:0] rx_cnt;
		logic [tac_pkg::CB_W-3:0] rx_sh;
		logic [2:0] chan;
		logic eight;
		logic single;
		logic [1:0] pd;
		logic ref_on;
		logic conv_pend;
		logic [2:0] cv_ch;
		logic cv_single;
		logic busy;
		logic [3:0] tx_left;
		logic [tac_pkg::RES_BITS-1:0] tx_sh;
		logic sdo;
		logic oe;
		logic drive;
		logic powered;
		logic acq;
		logic irq_n;
		logic fresh;
	} tac_dev_s;

	// powered from the start until a keep-clear byte, pen output idle high
	localparam tac_dev_s DEV_RST = '{
		pd: tac_pkg::PD_RESET,
		powered: 1'b1,
		fresh: 1'b1,
		irq_n: 1'b1,
		default: '0
	};

	tac_dev_s s;
	tac_dev_s n;
	logic rise;
	logic fall;
	logic conv;
	logic [tac_pkg::CB_W-1:0] cbyte;

	function automatic logic tac_touch_ch(input logic [2:0] ch);
		return tac_pkg::TOUCH_CH_MASK[ch];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// serial clock edges, seen in the system clock domain

	assign rise = link.serial_clock_in & ~s.sclk_q;
	assign fall = ~link.serial_clock_in & s.sclk_q;

	// whole control byte as it stands on the last bit
	assign cbyte = {1'b1, s.rx_sh, link.sdi};

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		n = s;
		conv = 1'b0;
		n.sclk_q = link.serial_clock_in;
		if (link.cs_n) begin
			// abandon everything in flight; keep power bits and reference
			n.rx_on = 1'b0;
			n.rx_cnt = 3'h0;
			n.conv_pend = 1'b0;
			n.busy = 1'b0;
			n.tx_left = 4'h0;
			n.sdo = 1'b0;
			n.oe = 1'b0;
			n.ref_on = s.ref_on;
		end else begin
			n.oe = 1'b1;

			// control byte receiver, independent of the result shifter
			if (rise && !s.rx_on && link.sdi) begin
				n.rx_on = 1'b1;
				n.rx_cnt = 3'h0;
			end else if (rise && s.rx_on) begin
				n.rx_sh = {s.rx_sh[tac_pkg::CB_W-4:0], link.sdi};
				n.rx_cnt = s.rx_cnt + 3'h1;
				if (s.rx_cnt == 3'h2) begin
					// channel known early so acquisition can begin
					n.chan = {s.rx_sh[1:0], link.sdi};
				end
				if (s.rx_cnt == 3'h6) begin
					n.rx_on = 1'b0;
					n.conv_pend = 1'b1;
					n.chan = cbyte[tac_pkg::CB_CH_LSB +: 3];
					n.eight = cbyte[tac_pkg::CB_MODE];
					n.single = cbyte[tac_pkg::CB_SER];
					n.pd = {cbyte[tac_pkg::CB_PD1], cbyte[tac_pkg::CB_PD0]};
					if (!cbyte[tac_pkg::CB_PD0]) begin
						n.fresh = 1'b0;
					end
				end
			end

			// result shifter: busy drops and the msb leaves on one fall
			if (fall) begin
				n.busy = 1'b0;
				if (s.tx_left != 4'h0) begin
					n.sdo = s.tx_sh[tac_pkg::RES_BITS-1];
					n.tx_sh = {s.tx_sh[tac_pkg::RES_BITS-2:0], 1'b0};
					n.tx_left = s.tx_left - 4'h1;
				end else begin
					n.sdo = 1'b0;
				end
				if (s.conv_pend) begin
					// end of acquisition; hold the sample, start converting
					n.conv_pend = 1'b0;
					n.busy = 1'b1;
					n.cv_ch = s.chan;
					n.cv_single = s.single;
					n.tx_sh = analog_code[s.chan];
					n.tx_left = s.eight ? 4'(tac_pkg::RES_BITS - tac_pkg::RES_SHORTEN)
						: 4'(tac_pkg::RES_BITS);
					// reference follows the high power bit, latched with busy
					n.ref_on = s.pd[1];
				end
			end
		end

		conv = n.busy || n.tx_left != 4'h0;
		n.acq = (n.rx_on && n.rx_cnt >= 3'(tac_pkg::ACQ_FROM_BIT)) || n.conv_pend;

		// drivers follow the reference mode of each phase
		n.drive = (n.acq && tac_touch_ch(n.chan))
			|| (conv && !n.cv_single && tac_touch_ch(n.cv_ch));

		// full power from start, or with select low on keep bit or while conversion work is open
		n.powered = n.fresh
			|| (!link.cs_n && (n.pd[0] || n.rx_on || n.acq || conv));

		// pen detect only while idle with the keep bit clear
		if (conv) begin
			n.irq_n = !tac_touch_ch(n.cv_ch);
		end else if (n.pd[0]) begin
			n.irq_n = 1'b1;
		end else begin
			n.irq_n = !panel_touched;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= DEV_RST;
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all from the state register

	assign link.sdo = s.sdo;
	assign link.sdo_oe = s.oe;
	assign link.busy = s.busy;
	assign link.busy_oe = s.oe;
	assign channel_select_field = s.chan;
	assign touch_drive_on = s.drive;
	assign adc_powered = s.powered;
	assign ref_powered = s.ref_on;
	assign acquiring = s.acq;
	assign touch_irq_n = s.irq_n;
endmodule // tac_dev

// ===== tb/tac_link_properties.sv
// tac_link_properties: timing relations on the converter link
module tac_link_properties (
	input wire logic clk, // system clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic serial_clock_in, // serial clock
	input wire logic cs_n, // chip select, active low
	input wire logic sdi, // control data
	input wire logic sdo, // result data
	input wire logic sdo_oe, // result data enable
	input wire logic busy, // conversion busy
	input wire logic busy_oe // busy enable
);
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic sclk_q;
		logic busy_q;
		logic have_prev;
		logic [7:0] rises;
	} tac_chk_s;
	tac_chk_s st;
	tac_chk_s next_st;
	////////////////////////////////////////////////////////////////////////
	// serial clock rises since the last busy rise
	always_comb begin
		next_st = st;
		next_st.sclk_q = serial_clock_in;
		next_st.busy_q = busy;
		if (busy && !st.busy_q) begin
			next_st.have_prev = 1'b1;
			next_st.rises = 8'h00;
		end else if (serial_clock_in && !st.sclk_q && st.rises != 8'hFF) begin
			next_st.rises = st.rises + 8'h01;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_cs_open;
		$fell(cs_n);
	endsequence
	sequence s_busy_period;
		busy[*8] ##1 busy[*7] ##[1:4] !busy;
	endsequence
	property p_cs_setup;
		s_cs_open |-> (!serial_clock_in)[*4];
	endproperty
	a_cs_setup: assert property (p_cs_setup) else $error("clock moved too soon");
	property p_start_busy;
		s_cs_open |-> ##[100:200] $rose(busy);
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("busy late");
	property p_busy_len;
		$rose(busy) |-> s_busy_period;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	property p_busy_low_clk;
		$rose(busy) |-> !serial_clock_in;
	endproperty
	a_busy_low_clk: assert property (p_busy_low_clk) else $error("busy off edge");
	property p_sdo_on_fall;
		sdo_oe && $stable(sdo_oe) && $changed(sdo) |-> !serial_clock_in;
	endproperty
	a_sdo_on_fall: assert property (p_sdo_on_fall) else $error("data off edge");
	property p_sdi_on_fall;
		!cs_n && $changed(sdi) |-> !serial_clock_in;
	endproperty
	a_sdi_on_fall: assert property (p_sdi_on_fall) else $error("control off edge");
	property p_cs_release;
		cs_n |=> !sdo_oe && !busy_oe;
	endproperty
	a_cs_release: assert property (p_cs_release) else $error("outputs still on");
	property p_busy_quiet;
		!busy_oe |-> !busy;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("busy while off");
	property p_spacing;
		$rose(busy) && st.have_prev |-> st.rises >= 8'h0B;
	endproperty
	a_spacing: assert property (p_spacing) else $error("conversions too close");
	property p_clock_idle;
		cs_n && $past(cs_n, 2) |-> !serial_clock_in;
	endproperty
	a_clock_idle: assert property (p_clock_idle) else $error("clock runs idle");
endmodule // tac_link_properties

// ===== tb/touch_adc_serial_conversion_test.sv
// touch_adc_serial_conversion_test: master and converter joined end to end
module touch_adc_serial_conversion_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk;
	logic rst_n;
	logic [5:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [7:0][11:0] codes;
	logic panel_touched, drive_on, adc_pw, ref_pw, acq, irq_n, busy_d, drive_seen, acq_seen;
	logic [2:0] chan;
	logic [31:0] d;
	logic [1:0] r;
	int failures, checks_done, n, gap_cnt, gap;
	tac_link_if tac_link_if_i ();
	tac_host tac_host_i (.clk(clk), .rst_n(rst_n), .link(tac_link_if_i), .s_awaddr(awaddr),
		.s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb),
		.s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
		.s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
		.s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
	tac_dev tac_dev_i (.clk(clk), .rst_n(rst_n), .link(tac_link_if_i), .analog_code(codes),
		.panel_touched(panel_touched), .channel_select_field(chan), .touch_drive_on(drive_on),
		.adc_powered(adc_pw), .ref_powered(ref_pw), .acquiring(acq), .touch_irq_n(irq_n));
	tac_link_properties tac_link_properties_i (.clk(clk), .rst_n(rst_n),
		.serial_clock_in(tac_link_if_i.serial_clock_in), .cs_n(tac_link_if_i.cs_n),
		.sdi(tac_link_if_i.sdi), .sdo(tac_link_if_i.sdo), .sdo_oe(tac_link_if_i.sdo_oe),
		.busy(tac_link_if_i.busy), .busy_oe(tac_link_if_i.busy_oe));
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// drivers past the first conversion cycle; clocks between busy rises
	always @(posedge clk) begin
		busy_d <= tac_link_if_i.busy;
		gap_cnt <= (tac_link_if_i.busy && !busy_d) ? 1 : gap_cnt + 1;
		if (tac_link_if_i.busy && !busy_d) gap <= gap_cnt;
		if (tac_link_if_i.busy && busy_d && drive_on) drive_seen = 1'b1;
		if (acq && !tac_link_if_i.busy) acq_seen = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic results();
		if (failures == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic bound(input int cnt, input int lim);
		if (cnt >= lim) begin
			failures++;
			results();
		end
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic axw(input logic [5:0] a, input logic [31:0] v, output logic [1:0] resp);
		int k;
		@(posedge clk);
		k = 0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			k++;
		end while (!bvalid && k < 300);
		resp = bresp;
		bready <= 1'b0;
		bound(k, 300);
	endtask
	task automatic axr(input logic [5:0] a, output logic [31:0] v, output logic [1:0] resp);
		int k;
		@(posedge clk);
		k = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			k++;
		end while (!rvalid && k < 300);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
		bound(k, 300);
	endtask
	// wait for the next result, compare it
	task automatic fetch(input logic [31:0] exp);
		logic [31:0] v;
		logic [1:0] resp;
		int k;
		k = 0;
		v = 32'h0;
		while (v[2] !== 1'b1 && k < 1000) begin
			axr(tac_pkg::A_STAT, v, resp);
			k++;
		end
		bound(k, 1000);
		axr(tac_pkg::A_RES, v, resp);
		chk(v, exp);
	endtask
	// one command, its result, its channel and its acquisition
	task automatic conv(input logic [2:0] ch, input logic [3:0] low, input logic [31:0] exp);
		logic [1:0] resp;
		drive_seen = 1'b0;
		acq_seen = 1'b0;
		axw(tac_pkg::A_CMD, {24'h000000, 1'b1, ch, low}, resp);
		fetch(exp);
		repeat (2 * tac_pkg::SCLK_HALF_CYC) @(posedge clk);
		chk(32'(chan), 32'(ch));
		chk(32'(acq_seen), 32'h1);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		failures = 0;
		checks_done = 0;
		rst_n = 1'b0;
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hF;
		panel_touched = 1'b0;
		drive_seen = 1'b0;
		codes = {12'hFFE, 12'h001, 12'h35A, 12'hA5C, 12'h7FE, 12'h801, 12'hFFF, 12'h000};
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk(32'(adc_pw), 32'h1);
		chk(32'(ref_pw), 32'h0);
		axr(tac_pkg::A_STAT, d, r);
		chk(d, 32'h0);
		axr(6'h10, d, r);
		chk({d[29:0], r}, {30'h0, tac_pkg::RESP_SLVERR});
		axw(tac_pkg::A_CFG, 32'h2, r);
		panel_touched <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			conv(3'(i), {2'h1, 2'(i)}, 32'(codes[i]));
			chk(32'(ref_pw), 32'(i / 2));
			chk(32'(adc_pw), 32'(i % 2));
			chk(32'(irq_n), 32'(i % 2));
		end
		conv(3'h4, 4'hB, 32'(codes[4][11:4]));
		axw(tac_pkg::A_CFG, 32'h3, r);
		axw(tac_pkg::A_CMD, {24'h000000, 1'b1, 3'h5, 4'h7}, r);
		axw(tac_pkg::A_CMD, {24'h000000, 1'b1, 3'h2, 4'h7}, r);
		fetch(32'(codes[5]));
		fetch(32'(codes[2]));
		chk(32'(gap), 32'(tac_pkg::FRAME_FAST * 2 * tac_pkg::SCLK_HALF_CYC));
		conv(3'h5, 4'h7, 32'(codes[5]));
		conv(3'h6, 4'hF, 32'(codes[6][11:4]));
		conv(3'h1, 4'h7, 32'(codes[1]));
		chk(32'(drive_seen), 32'h0);
		conv(3'h1, 4'h3, 32'(codes[1]));
		chk(32'(drive_seen), 32'h1);
		axw(tac_pkg::A_CFG, 32'h0, r);
		conv(3'h7, 4'h7, 32'(codes[7]));
		n = 0;
		while (tac_link_if_i.cs_n !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		bound(n, 100);
		@(posedge clk);
		chk(32'(adc_pw), 32'h0);
		chk(32'(ref_pw), 32'h1);
		conv(3'h7, 4'h5, 32'(codes[7]));
		chk(32'(ref_pw), 32'h0);
		results();
	end
endmodule // touch_adc_serial_conversion_test
